// ### pmcd_pkg.sv
// Package: constants and types of the power management clock divider
// Summary of operation
// - Slow mode gives one tick per 1024 clocks
// - Select codes 00 mult, 10 one, 11 slow
// - Select resets 10; non-10 writes need 10
// - Bit 5 enables switchback, resets to zero
// - Switchback forces select 10 next clock; divide-by-one from the next slow cycle edge
// - Status bits 7:5 show level, zero idle
// - Levels 0-3 code 001-100, power-fail 101
// - Status bits 3:0 show serial unit activity
// - Crystal keeps running, only system clock divided
// - Signal timing in system cycles stays unchanged
// - All system-clocked functions slow by same factor
// - Direct moves between non-10 settings are ignored
// - Only acknowledged qualified interrupts cause switchback
// - Serial switchback on start edge or buffer load
package pmcd_pkg;

    // ************************************************
    // Register map and fields
    // ************************************************
    localparam int         AXI_AW      = 12;
    localparam logic [7:0] PMR_INDEX   = 8'hC4;
    localparam logic [7:0] STAT_INDEX  = 8'hC5;
    localparam logic [9:0] PMR_WORD    = {2'h0, PMR_INDEX};
    localparam logic [9:0] STAT_WORD   = {2'h0, STAT_INDEX};
    localparam int         DIV_HI_POS  = 7;
    localparam int         DIV_LO_POS  = 6;
    localparam int         FRE_POS     = 5;
    localparam int         LVL_HI_POS  = 7;
    localparam int         LVL_LO_POS  = 5;
    localparam int         P1_TX_POS   = 3;
    localparam int         P1_RX_POS   = 2;
    localparam int         P0_TX_POS   = 1;
    localparam int         P0_RX_POS   = 0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************
    // Divider codes and timing
    // ************************************************
    typedef logic [1:0] pmcd_div_sel_type;
    localparam pmcd_div_sel_type DIV_XMUL = 2'h0;
    localparam pmcd_div_sel_type DIV_RSVD = 2'h1;
    localparam pmcd_div_sel_type DIV_ONE  = 2'h2;
    localparam pmcd_div_sel_type DIV_SLOW = 2'h3;
    localparam int               SLOW_RATIO = 1024;
    localparam int               CNT_W      = 10;
    localparam logic [CNT_W-1:0] CNT_MAX    = CNT_W'(SLOW_RATIO - 1);
    localparam int               IRQ_LEVELS = 5;
    localparam logic [2:0]       LVL_NONE   = 3'h0;
    localparam logic [2:0]       LVL_PFAIL  = 3'h5;
    localparam logic             FRE_RESET  = 1'h0;
    localparam logic [1:0]       RXD_IDLE   = 2'h3;

    // ************************************************
    // Types
    // ************************************************
    typedef struct packed {
        logic [1:0] rxd;
        logic [1:0] rx_en;
        logic [1:0] tx_load;
        logic [1:0] tx_active;
        logic [1:0] rx_active;
    } pmcd_serial_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } pmcd_wr_state_type;

    typedef struct packed {
        pmcd_wr_state_type wst;
        logic              awready;
        logic              wready;
        logic              aw_got;
        logic              w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [7:0]        wdata;
        logic              wstrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        pmcd_div_sel_type  div_sel;
        logic              fast_ret;
        logic              sb_pulse;
        logic [7:0]        status;
        logic [1:0]        rxd_prev;
    } pmcd_top_state_type;

    localparam pmcd_top_state_type TOP_RESET = '{
        wst: WR_IDLE, awready: 1'h1, wready: 1'h1, aw_got: 1'h0,
        w_got: 1'h0, awaddr: 12'h000, wdata: 8'h00, wstrb0: 1'h0,
        bvalid: 1'h0, bresp: RESP_OKAY, arready: 1'h1, rvalid: 1'h0,
        rdata: 32'h0000_0000, rresp: RESP_OKAY, div_sel: DIV_ONE,
        fast_ret: FRE_RESET, sb_pulse: 1'h0, status: 8'h00,
        rxd_prev: RXD_IDLE
    };

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             slow;
        logic             tick;
    } pmcd_div_state_type;

    localparam pmcd_div_state_type DIV_RESET = '{
        cnt: 10'h000, slow: 1'h0, tick: 1'h0
    };

endpackage

// ### pmcd_sysclk_div.sv
// System cycle strobe generator dividing the crystal clock
`timescale 1ns/1ns
`default_nettype none
module pmcd_sysclk_div (
    // Clock, reset and enable
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    // Divider select
    input  wire pmcd_pkg::pmcd_div_sel_type div_sel,
    // System cycle strobe and mode
    output logic                            tick,
    output logic                            slow
);
    import pmcd_pkg::*;

    pmcd_div_state_type q;
    pmcd_div_state_type d;
    logic               boundary;

    // ************************************************
    // Counter
    // ************************************************
    // Clock itself is never gated, only the strobe is divided
    assign boundary = (q.cnt == (q.slow ? CNT_MAX : '0));

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (boundary) begin
            // New ratio only at a cycle edge: no short cycle
            d.cnt  = '0;
            d.tick = 1'b1;
            d.slow = (div_sel == DIV_SLOW);
        end else begin
            d.cnt = q.cnt + CNT_W'(1);
        end
        if (!ce) begin
            d = q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= DIV_RESET;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
    assign slow = q.slow;

    // ************************************************
    // Checks
    // ************************************************
    fast_tick_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (ce && !q.slow) |=> q.tick)
        else $error("divide-by-one missed a tick");

    slow_gap_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (ce && q.slow && q.cnt != CNT_MAX) |=> !q.tick)
        else $error("slow mode tick too early");

    ratio_edge_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $changed(q.slow) |-> (q.cnt == '0 && q.tick))
        else $error("ratio changed inside a cycle");

endmodule
`default_nettype wire

// ### pmcd_power_clock.sv
// Power management clock divider with register slave and status
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module pmcd_power_clock (
    // Clock, reset and enable
    input  wire logic                       REF_CLK,
    input  wire logic                       NRST,
    input  wire logic                       CLK_EN,
    // Register write address
    input  wire logic [pmcd_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    // Register write data
    input  wire logic [31:0]                S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    // Register write response
    output logic [1:0]                      S_AXI_BRESP,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    // Register read address
    input  wire logic [pmcd_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    // Register read data
    output logic [31:0]                     S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    // Interrupt controller
    input  wire logic                       IRQ_ACK,
    input  wire logic [4:0]                 IRQ_IN_SERVICE,
    // Serial ports
    input  wire pmcd_pkg::pmcd_serial_type  SERIAL,
    // System clock control
    output logic                            SYS_TICK,
    output logic                            SLOW_MODE,
    output logic [1:0]                      DIV_SELECT,
    output logic                            SWITCHBACK
);
    import pmcd_pkg::*;

    pmcd_top_state_type q;
    pmcd_top_state_type d;

    logic             wr_pmr;
    logic             wr_stat;
    logic             wr_hit;
    logic             rd_pmr;
    logic             rd_stat;
    logic             do_write;
    logic             pmr_wr;
    pmcd_div_sel_type new_sel;
    logic             sel_ok;
    logic [1:0]       rx_fall;
    logic [1:0]       port_ev;
    logic             sb_event;
    logic             sb_take;
    logic [2:0]       lvl_now;
    logic [7:0]       pmr_view;

    // ************************************************
    // Helpers
    // ************************************************
    // Highest level in service wins; code is level plus one
    function automatic logic [2:0] lvl_code(input logic [4:0] v);
        lvl_code = LVL_NONE;
        for (int i = 0; i < IRQ_LEVELS; i++) begin
            if (v[i]) begin
                lvl_code = 3'(i + 1);
            end
        end
    endfunction

    // ************************************************
    // Address decode
    // ************************************************
    assign wr_pmr  = (q.awaddr[AXI_AW-1:2] == PMR_WORD);
    assign wr_stat = (q.awaddr[AXI_AW-1:2] == STAT_WORD);
    assign wr_hit  = wr_pmr | wr_stat;
    assign rd_pmr  = (S_AXI_ARADDR[AXI_AW-1:2] == PMR_WORD);
    assign rd_stat = (S_AXI_ARADDR[AXI_AW-1:2] == STAT_WORD);

    assign do_write = q.aw_got & q.w_got & (q.wst == WR_IDLE);
    assign pmr_wr   = do_write & wr_pmr & q.wstrb0;
    assign new_sel  = q.wdata[DIV_HI_POS:DIV_LO_POS];
    // Any code may be written from 10, only 10 from elsewhere
    assign sel_ok   = (new_sel == DIV_ONE) || (q.div_sel == DIV_ONE);

    assign pmr_view = {q.div_sel, q.fast_ret, 5'h00};
    assign lvl_now  = lvl_code(IRQ_IN_SERVICE);

    // ************************************************
    // Switchback sources
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_port
            // Start bit edge; interrupt flags play no part
            assign rx_fall[gi] = q.rxd_prev[gi] & ~SERIAL.rxd[gi];
            assign port_ev[gi] = (rx_fall[gi] & SERIAL.rx_en[gi])
                               | SERIAL.tx_load[gi];
        end
    endgenerate

    // Acknowledge already means enabled and not blocked
    assign sb_event = IRQ_ACK | (|port_ev);
    assign sb_take  = q.fast_ret & sb_event;

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        d = q;
        d.sb_pulse = 1'b0;

        // Address and data may arrive in either order
        if (S_AXI_AWVALID && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && q.wready) begin
            d.w_got  = 1'b1;
            d.wdata  = S_AXI_WDATA[7:0];
            d.wstrb0 = S_AXI_WSTRB[0];
        end

        unique case (q.wst)
            WR_IDLE: begin
                if (do_write) begin
                    d.wst    = WR_RESP;
                    d.bvalid = 1'b1;
                    d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
                    d.aw_got = 1'b0;
                    d.w_got  = 1'b0;
                end
            end
            WR_RESP: begin
                if (S_AXI_BREADY) begin
                    d.wst    = WR_IDLE;
                    d.bvalid = 1'b0;
                end
            end
        endcase
        d.awready = (d.wst == WR_IDLE) && !d.aw_got;
        d.wready  = (d.wst == WR_IDLE) && !d.w_got;

        // Status is read only; writes to it are dropped
        if (pmr_wr) begin
            d.fast_ret = q.wdata[FRE_POS];
            if (sel_ok) begin
                d.div_sel = new_sel;
            end
        end

        // Switchback beats a software write in the same cycle
        if (sb_take) begin
            d.div_sel  = DIV_ONE;
            d.sb_pulse = 1'b1;
        end

        // Read channel: one read outstanding
        if (S_AXI_ARVALID && q.arready) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = RESP_OKAY;
            if (rd_pmr) begin
                d.rdata = {24'h00_0000, pmr_view};
            end else if (rd_stat) begin
                d.rdata = {24'h00_0000, q.status};
            end else begin
                d.rdata = 32'h0000_0000;
                d.rresp = RESP_SLVERR;
            end
        end else if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        // Snapshot lets software defer a slowdown
        d.status[LVL_HI_POS:LVL_LO_POS] = lvl_now;
        d.status[4]         = 1'b0;
        d.status[P1_TX_POS] = SERIAL.tx_active[1];
        d.status[P1_RX_POS] = SERIAL.rx_active[1];
        d.status[P0_TX_POS] = SERIAL.tx_active[0];
        d.status[P0_RX_POS] = SERIAL.rx_active[0];
        d.rxd_prev = SERIAL.rxd;

        if (!CLK_EN) begin
            d = q;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            q <= TOP_RESET;
        end else begin
            q <= d;
        end
    end

    // ************************************************
    // System cycle strobe
    // ************************************************
    // Timers, baud and watchdog run off SYS_TICK, so all
    // of them slow down together and keep cycle timing
    pmcd_sysclk_div u_div (
        .clk     (REF_CLK),
        .nrst    (NRST),
        .ce      (CLK_EN),
        .div_sel (q.div_sel),
        .tick    (SYS_TICK),
        .slow    (SLOW_MODE)
    );

    // ************************************************
    // Outputs
    // ************************************************
    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY  = q.wready;
    assign S_AXI_BRESP   = q.bresp;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RDATA   = q.rdata;
    assign S_AXI_RRESP   = q.rresp;
    assign S_AXI_RVALID  = q.rvalid;
    assign DIV_SELECT    = q.div_sel;
    assign SWITCHBACK    = q.sb_pulse;

    // ************************************************
    // Checks
    // ************************************************
    wr_accept_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (CLK_EN && pmr_wr && sel_ok && !sb_take)
        |=> (DIV_SELECT == $past(new_sel)))
        else $error("legal select write not taken");

    sel_illegal_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (CLK_EN && pmr_wr && !sel_ok && !sb_take)
        |=> $stable(DIV_SELECT))
        else $error("illegal select move taken");

    swb_off_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (!q.fast_ret && !pmr_wr) |=> $stable(DIV_SELECT))
        else $error("select moved without write");

    swb_force_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (CLK_EN && q.fast_ret && IRQ_ACK)
        |=> (DIV_SELECT == DIV_ONE) ##0 SWITCHBACK)
        else $error("interrupt switchback missed");

    rx_edge_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (CLK_EN && q.fast_ret && SERIAL.rx_en[0]
         && q.rxd_prev[0] && !SERIAL.rxd[0])
        |=> (DIV_SELECT == DIV_ONE))
        else $error("receive edge switchback missed");

    lvl_pfail_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (CLK_EN && IRQ_IN_SERVICE[4])
        |=> (q.status[LVL_HI_POS:LVL_LO_POS] == LVL_PFAIL))
        else $error("power-fail level code wrong");

    lvl_idle_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (CLK_EN && IRQ_IN_SERVICE == 5'h00)
        |=> (q.status[LVL_HI_POS:LVL_LO_POS] == LVL_NONE))
        else $error("idle level not zero");

    act_bits_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        CLK_EN |=> (({q.status[P1_TX_POS], q.status[P0_TX_POS]}
            == $past(SERIAL.tx_active))
         && ({q.status[P1_RX_POS], q.status[P0_RX_POS]}
            == $past(SERIAL.rx_active))))
        else $error("activity bits wrong");

endmodule
`default_nettype wire

// ### pmcd_core_model.sv
// Model of the core, interrupt controller and serial ports
`timescale 1ns/1ns
`default_nettype none
module pmcd_core_model (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Bench commands
    input  wire logic [2:0]           ev,
    input  wire logic [4:0]           lvl,
    input  wire logic [3:0]           act,
    input  wire logic [1:0]           rxen,
    // Towards the divider
    output logic                      irq_ack,
    output logic [4:0]                in_service,
    output pmcd_pkg::pmcd_serial_type serial
);
    import pmcd_pkg::*;
    logic [1:0] low0_q;
    logic [1:0] low1_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_ack    <= 1'b0;
            in_service <= 5'h00;
            serial     <= '{rxd: RXD_IDLE, default: '0};
            low0_q     <= 2'h0;
            low1_q     <= 2'h0;
        end else begin
            // Ack only once the interrupt was enabled and won priority
            irq_ack           <= (ev == 3'h1);
            serial.tx_load    <= {ev == 3'h3, ev == 3'h2};
            // Start bit holds the pin low a few cycles, idle high otherwise
            low0_q            <= (ev == 3'h4) ? 2'h2 : low0_q - 2'(low0_q != 2'h0);
            low1_q            <= (ev == 3'h5) ? 2'h2 : low1_q - 2'(low1_q != 2'h0);
            serial.rxd        <= {!(ev == 3'h5 || low1_q != 2'h0),
                                  !(ev == 3'h4 || low0_q != 2'h0)};
            serial.rx_en      <= rxen;
            serial.tx_active  <= {act[3], act[1]};
            serial.rx_active  <= {act[2], act[0]};
            in_service        <= lvl;
        end
    end
endmodule
`default_nettype wire

// ### test_power_management_clock_divider.sv
// Self-checking bench of the power management clock divider
`timescale 1ns/1ns
`default_nettype none
module test_power_management_clock_divider;
    import pmcd_pkg::*;
    localparam logic [11:0] PMR_A  = {PMR_WORD, 2'h0};
    localparam logic [11:0] STAT_A = {STAT_WORD, 2'h0};
    localparam logic [11:0] BAD_A  = 12'h400;
    logic            clk, nrst, awv, wv, brdy, arv, rrdy, ce;
    logic            awr, wr, bv, arr, rv, tick, slow, sbk, ack;
    logic [11:0]     awa, ara;
    logic [31:0]     wd, rd;
    logic [3:0]      ws, act;
    logic [1:0]      br, rr, dsel, rxen;
    logic [4:0]      ins, lvl;
    logic [2:0]      ev;
    pmcd_serial_type ser;
    int              mismatches, checks;

    pmcd_power_clock i_pmcd_power_clock (
        .REF_CLK(clk), .NRST(nrst), .CLK_EN(ce),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
        .IRQ_ACK(ack), .IRQ_IN_SERVICE(ins), .SERIAL(ser),
        .SYS_TICK(tick), .SLOW_MODE(slow), .DIV_SELECT(dsel), .SWITCHBACK(sbk));
    pmcd_core_model i_pmcd_core_model (
        .clk(clk), .nrst(nrst), .ev(ev), .lvl(lvl), .act(act), .rxen(rxen),
        .irq_ack(ack), .in_service(ins), .serial(ser));

    // ************************************************
    // Bus cycles and checking
    // ************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic timed_out();
        mismatches++;
        $display("wrong value wait expected end seen timeout");
        give_verdict();
    endtask
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge clk);
        awa  <= a;
        wd   <= d;
        ws   <= s;
        awv  <= 1'b1;
        wv   <= 1'b1;
        brdy <= 1'b1;
        b_hs = 1'b0;
        for (int n = 0; n < 64 && !b_hs; n++) begin
            @(negedge clk);
            aw_hs = awv & awr;
            w_hs  = wv & wr;
            b_hs  = bv & brdy;
            r     = br;
            @(posedge clk);
            if (aw_hs) awv <= 1'b0;
            if (w_hs) wv <= 1'b0;
            if (b_hs) brdy <= 1'b0;
        end
        if (!b_hs) timed_out();
    endtask
    task automatic reg_is(input logic [11:0] a, input logic [31:0] expv, input logic [1:0] er,
                          input string what);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        ara  <= a;
        arv  <= 1'b1;
        rrdy <= 1'b1;
        r_hs = 1'b0;
        for (int n = 0; n < 64 && !r_hs; n++) begin
            @(negedge clk);
            ar_hs = arv & arr;
            r_hs  = rv & rrdy;
            d     = rd;
            r     = rr;
            @(posedge clk);
            if (ar_hs) arv <= 1'b0;
            if (r_hs) rrdy <= 1'b0;
        end
        if (!r_hs) timed_out();
        check(what, d, expv);
        check(what, 32'(r), 32'(er));
    endtask
    task automatic count_ticks(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            c += int'(tick === 1'b1);
        end
    endtask
    task automatic wait_tick();
        int n;
        for (n = 0; n < 1100; n++) begin
            @(negedge clk);
            if (tick === 1'b1) break;
        end
        if (n == 1100) timed_out();
    endtask
    // Event goes to the model for one cycle, switchback pulse is collected
    task automatic fire(input logic [2:0] code, output logic sb);
        @(posedge clk);
        ev <= code;
        @(posedge clk);
        ev <= 3'h0;
        sb = 1'b0;
        repeat (6) begin
            @(negedge clk);
            sb |= sbk;
        end
    endtask
    function automatic logic [2:0] exp_level(input logic [4:0] m);
        exp_level = LVL_NONE;
        for (int i = 0; i < IRQ_LEVELS; i++) begin
            if (m[i]) exp_level = 3'(i + 1);
        end
    endfunction
    function automatic logic [1:0] exp_sel(input logic [1:0] cur, input logic [1:0] req);
        exp_sel = (cur == DIV_ONE || req == DIV_ONE) ? req : cur;
    endfunction

    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        logic [1:0] r, sel;
        logic [31:0] v;
        logic [3:0] s;
        logic sb, fre;
        int c;
        {nrst, awv, wv, brdy, arv, rrdy, awa, ara, wd, ws} = '0;
        {ev, lvl, act, rxen, mismatches, checks} = '0;
        ce = 1'b1;
        c = $urandom(32'h5D4A);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check("reset select", 32'(dsel), 32'(DIV_ONE));
        reg_is(PMR_A, 32'h80, RESP_OKAY, "pmr reset");
        reg_is(STAT_A, 32'h0, RESP_OKAY, "status reset");
        count_ticks(16, c);
        check("fast ticks", 32'(c), 32'd16);
        axi_write(BAD_A, 32'hFF, 4'hF, r);
        check("bad write", 32'(r), 32'(RESP_SLVERR));
        reg_is(BAD_A, 32'h0, RESP_SLVERR, "bad read");
        axi_write(STAT_A, 32'hFF, 4'hF, r);
        reg_is(STAT_A, 32'h0, RESP_OKAY, "status read only");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            lvl <= (i == 0) ? 5'h00 : (i < 6) ? 5'(1 << (i - 1)) : 5'($urandom);
            act <= 4'($urandom);
            repeat (3) @(posedge clk);
            reg_is(STAT_A, {24'h0, exp_level(lvl), 1'b0, act}, RESP_OKAY, "status");
        end
        lvl <= 5'h00;
        act <= 4'h0;
        repeat (3) @(posedge clk);
        // Slowing down is only safe with no service or traffic under way
        reg_is(STAT_A, 32'h0, RESP_OKAY, "idle before slow");
        for (int k = 0; k < 2; k++) begin
            axi_write(PMR_A, {24'h0, 2'(k), 6'h0}, 4'h1, r);
            check("select code", 32'(dsel), 32'(k));
            count_ticks(8, c);
            check("code ticks", 32'(c), 32'd8);
            axi_write(PMR_A, 32'h80, 4'h1, r);
        end
        axi_write(PMR_A, 32'hC0, 4'h1, r);
        axi_write(PMR_A, 32'h00, 4'h1, r);
        check("no direct move", 32'(dsel), 32'(DIV_SLOW));
        count_ticks(4, c);
        wait_tick();
        count_ticks(1023, c);
        check("slow gap", 32'(c), 32'd0);
        count_ticks(1, c);
        check("slow tick", 32'(c), 32'd1);
        check("slow flag", 32'(slow), 32'd1);
        fire(3'h1, sb);
        check("fre off", {1'b0, sb, 28'h0, dsel}, 32'(DIV_SLOW));
        axi_write(PMR_A, 32'hE0, 4'h1, r);
        reg_is(PMR_A, 32'hE0, RESP_OKAY, "fre on");
        rxen <= 2'h3;
        for (int k = 1; k < 6; k++) begin
            axi_write(PMR_A, 32'hE0, 4'h1, r);
            fire(3'(k), sb);
            check("switchback", {1'b0, sb, 28'h0, dsel}, {2'h1, 28'h0, DIV_ONE});
            wait_tick();
            count_ticks(8, c);
            check("back to fast", 32'(c), 32'd8);
        end
        rxen <= 2'h0;
        axi_write(PMR_A, 32'hE0, 4'h1, r);
        fire(3'h4, sb);
        check("rx disabled", {1'b0, sb, 28'h0, dsel}, 32'(DIV_SLOW));
        sel = DIV_SLOW;
        fre = 1'b1;
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            s = 4'($urandom);
            axi_write(PMR_A, v, s, r);
            if (s[0]) sel = exp_sel(sel, v[7:6]);
            if (s[0]) fre = v[5];
            reg_is(PMR_A, {24'h0, sel, fre, 5'h0}, RESP_OKAY, "random pmr");
        end
        // Enable low freezes all state, so an interrupt cannot switch back
        axi_write(PMR_A, 32'h80, 4'h1, r);
        axi_write(PMR_A, 32'hE0, 4'h1, r);
        ce <= 1'b0;
        fire(3'h1, sb);
        check("frozen", {1'b0, sb, 28'h0, dsel}, 32'(DIV_SLOW));
        @(posedge clk);
        ce <= 1'b1;
        give_verdict();
    end
endmodule
`default_nettype wire
